// ===== rtl/rilc_ctl.sv
// Purpose: reset, interrupt and stop/wait sequencing for an 8-bit core
// Assumes: all inputs synchronous to clock_in; cpu acts on the sequence outputs
// Notes: one state struct, one comb fill, one register stage
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
module rilc_ctl #(
    parameter bit          WDOG_FITTED  = 1'b1, // RULE24
    parameter bit          IRQ_LEVEL    = 1'b1, // RULE24
    parameter int          POR_CYCLES   = rilc_pkg::RILC_POR_CYCLES,
    parameter int          WDOG_STAGES  = rilc_pkg::RILC_WDOG_STAGES
) (
    input  wire logic                      clock_in,
    input  wire logic                      rst_in,
    input  wire logic                      reset_pin_n_in,
    input  wire logic                      irq_pin_n_in,
    input  wire rilc_pkg::rilc_cpu_req_type cpu_req_in,
    input  wire rilc_pkg::rilc_tflag_type  timer_flags_in,
    input  wire logic                      wr_in,
    input  wire logic                      rd_in,
    input  wire logic [15:0]               addr_in,
    input  wire logic [7:0]                wdata_in,
    output logic      [7:0]                rdata_out,
    output logic                           core_reset_out,
    output logic                           cpu_halt_out,
    output logic                           osc_run_out,
    output logic                           irq_mask_out,
    output rilc_pkg::rilc_ten_type         timer_en_out,
    output logic                           timer_en_clear_out,
    output logic                           periph_reset_out,
    output logic      [7:0]                sp_out,
    output logic      [15:0]               timer_load_out,
    output rilc_pkg::rilc_seq_out_type     seq_out,
    output rilc_pkg::rilc_mode_type        mode_out,
    output logic                           reset_pin_oe_n_out
);
    typedef struct packed {
        rilc_pkg::rilc_state_type st;
        rilc_pkg::rilc_mode_type  mode;
        logic [12:0]              por_cnt;
        logic                     por_done;
        logic [1:0]               pin_cnt;
        logic [WDOG_STAGES-1:0]   wdog;
        logic                     wdog_bite;
        logic                     irq_s1;
        logic                     irq_s2;
        logic                     irq_prev;
        logic                     irq_latch;
        logic                     mask;
        rilc_pkg::rilc_ten_type   ten;
        logic [7:0]               sp;
        logic [2:0]               slot;
        logic [15:0]              vec;
        logic                     trap_pend;
        logic [7:0]               rdata;
    } rilc_state_reg_type;

    rilc_state_reg_type s_q;
    rilc_state_reg_type s_d;

    function automatic logic timer_qual(input rilc_pkg::rilc_tflag_type f,
                                        input rilc_pkg::rilc_ten_type en);
        timer_qual = (f.capture_flag & en.capture_irq_enable) |
                     (f.compare_flag & en.compare_irq_enable) |
                     (f.overflow_flag & en.overflow_irq_enable);
    endfunction

    logic any_reset;
    logic irq_edge;
    logic irq_low;
    logic ext_pend;
    logic tim_pend;
    logic wdog_wr;

    always_comb begin
        irq_low   = ~s_q.irq_s2;
        irq_edge  = s_q.irq_prev & ~s_q.irq_s2; // RULE23
        ext_pend  = s_q.irq_latch | (IRQ_LEVEL & irq_low); // RULE21
        tim_pend  = timer_qual(timer_flags_in, s_q.ten); // RULE18
        wdog_wr   = wr_in & (addr_in == rilc_pkg::RILC_WDOG_ADDR) &
                    ~wdata_in[rilc_pkg::RILC_WDOG_CLR_BIT]; // RULE15
        // reset pin needs a stable low before it counts, a glitch is ignored
        any_reset = rst_in | ~s_q.por_done | s_q.wdog_bite |
                    (s_q.pin_cnt == rilc_pkg::RILC_RSTPIN_CYC); // RULE13 RULE14

        s_d           = s_q;
        s_d.wdog_bite = 1'b0;
        s_d.rdata     = 8'h00; // watchdog register is write-only, all reads zero

        // synchroniser then edge history, first stage read only by the second
        s_d.irq_s1   = irq_pin_n_in;
        s_d.irq_s2   = s_q.irq_s1;
        s_d.irq_prev = s_q.irq_s2;

        // power-on delay, then wait for the pin to rise
        if (!s_q.por_done) begin
            if (s_q.por_cnt < 13'(POR_CYCLES - 1)) begin
                s_d.por_cnt = s_q.por_cnt + 13'h1; // RULE12
            end else if (reset_pin_n_in) begin
                s_d.por_done = 1'b1; // RULE12
            end
        end
        if (!reset_pin_n_in) begin
            if (s_q.pin_cnt != rilc_pkg::RILC_RSTPIN_CYC) begin
                s_d.pin_cnt = s_q.pin_cnt + 2'h1;
            end
        end else begin
            s_d.pin_cnt = 2'h0;
        end

        // watchdog frozen in stop, running in wait
        if (WDOG_FITTED) begin
            if (wdog_wr) begin
                s_d.wdog = '0; // RULE15
            end else if (s_q.mode != rilc_pkg::RILC_MODE_STOP) begin // RULE1 RULE6
                s_d.wdog = s_q.wdog + 1'b1;
                if (&s_q.wdog) begin
                    s_d.wdog_bite = 1'b1; // RULE14
                end
            end
        end

        // edge latch; a new edge during service beats the fetch clear
        if (s_q.st == rilc_pkg::RILC_ST_VEC_HI && s_q.vec == rilc_pkg::RILC_VEC_EXT) begin
            s_d.irq_latch = 1'b0; // RULE20
        end
        if (irq_edge) begin
            s_d.irq_latch = 1'b1; // RULE20 RULE23
        end

        if (cpu_req_in.mask_set) begin
            s_d.mask = 1'b1;
        end else if (cpu_req_in.mask_clear) begin
            s_d.mask = 1'b0;
        end
        if (cpu_req_in.exec_trap && s_q.st == rilc_pkg::RILC_ST_RUN) begin
            s_d.trap_pend = 1'b1; // RULE22
        end
        // stop and reset below still win over a write in the same cycle
        if (wr_in && addr_in == rilc_pkg::RILC_TCR_ADDR) begin
            s_d.ten = wdata_in[rilc_pkg::RILC_TEN_MSB:rilc_pkg::RILC_TEN_LSB]; // RULE18
        end

        unique case (s_q.st)
            rilc_pkg::RILC_ST_RESET: begin
                s_d.st  = rilc_pkg::RILC_ST_VEC_HI;
                s_d.vec = rilc_pkg::RILC_VEC_RESET; // RULE11
            end
            rilc_pkg::RILC_ST_VEC_HI: begin
                s_d.st = rilc_pkg::RILC_ST_VEC_LO;
            end
            rilc_pkg::RILC_ST_VEC_LO: begin
                s_d.st = rilc_pkg::RILC_ST_RUN;
            end
            rilc_pkg::RILC_ST_RUN: begin
                unique case (s_q.mode)
                    rilc_pkg::RILC_MODE_STOP: begin
                        s_d.ten = '0; // RULE2
                        if (ext_pend) begin // RULE4
                            s_d.mode = rilc_pkg::RILC_MODE_RUN;
                            s_d.st   = rilc_pkg::RILC_ST_PUSH;
                            s_d.slot = rilc_pkg::RILC_SLOT_PCL;
                            s_d.vec  = rilc_pkg::RILC_VEC_EXT;
                        end
                    end
                    rilc_pkg::RILC_MODE_WAIT: begin
                        if (!s_q.mask && (ext_pend || tim_pend)) begin // RULE5
                            s_d.mode = rilc_pkg::RILC_MODE_RUN;
                            s_d.st   = rilc_pkg::RILC_ST_PUSH;
                            s_d.slot = rilc_pkg::RILC_SLOT_PCL;
                            s_d.vec  = ext_pend ? rilc_pkg::RILC_VEC_EXT
                                                : rilc_pkg::RILC_VEC_TIMER;
                        end
                    end
                    default: begin
                        if (cpu_req_in.exec_stop) begin
                            s_d.mode = rilc_pkg::RILC_MODE_STOP; // RULE1
                            s_d.mask = 1'b0; // RULE3
                            s_d.ten  = '0; // RULE2
                        end else if (cpu_req_in.exec_wait) begin
                            s_d.mode = rilc_pkg::RILC_MODE_WAIT;
                            s_d.mask = 1'b0; // RULE7
                        end else if (cpu_req_in.exec_return) begin
                            s_d.st   = rilc_pkg::RILC_ST_PULL; // RULE17
                            s_d.slot = rilc_pkg::RILC_SLOT_CCR;
                        end else if (cpu_req_in.instr_done) begin // RULE16
                            if (s_q.trap_pend || cpu_req_in.exec_trap) begin
                                s_d.st        = rilc_pkg::RILC_ST_PUSH;
                                s_d.slot      = rilc_pkg::RILC_SLOT_PCL;
                                s_d.vec       = rilc_pkg::RILC_VEC_TRAP; // RULE22
                                s_d.trap_pend = 1'b0;
                            end else if (!s_q.mask && ext_pend) begin // RULE19
                                s_d.st   = rilc_pkg::RILC_ST_PUSH;
                                s_d.slot = rilc_pkg::RILC_SLOT_PCL;
                                s_d.vec  = rilc_pkg::RILC_VEC_EXT;
                            end else if (!s_q.mask && tim_pend) begin // RULE18
                                s_d.st   = rilc_pkg::RILC_ST_PUSH;
                                s_d.slot = rilc_pkg::RILC_SLOT_PCL;
                                s_d.vec  = rilc_pkg::RILC_VEC_TIMER;
                            end
                        end
                    end
                endcase
            end
            rilc_pkg::RILC_ST_PUSH: begin
                s_d.sp = s_q.sp - 8'h01; // RULE16
                if (s_q.slot == rilc_pkg::RILC_STACK_LAST) begin
                    s_d.st   = rilc_pkg::RILC_ST_VEC_HI;
                    s_d.mask = 1'b1; // RULE16
                end else begin
                    s_d.slot = s_q.slot + 3'h1;
                end
            end
            rilc_pkg::RILC_ST_PULL: begin
                s_d.sp = s_q.sp + 8'h01; // RULE17
                if (s_q.slot == rilc_pkg::RILC_SLOT_PCL) begin
                    s_d.st = rilc_pkg::RILC_ST_RUN;
                end else begin
                    s_d.slot = s_q.slot - 3'h1;
                end
            end
        endcase

        // reset overrides state, mode, mask, stack, enables and latches and aborts the instruction at once
        if (any_reset) begin // RULE8
            s_d.st        = rilc_pkg::RILC_ST_RESET;
            s_d.mode      = rilc_pkg::RILC_MODE_RUN; // RULE9
            s_d.mask      = 1'b1; // RULE9
            s_d.sp        = rilc_pkg::RILC_SP_RESET; // RULE9
            s_d.ten       = '0; // RULE10
            s_d.wdog      = '0;
            s_d.irq_latch = 1'b0;
            s_d.trap_pend = 1'b0;
            s_d.slot      = rilc_pkg::RILC_SLOT_PCL;
        end
        if (rst_in) begin
            s_d.por_cnt   = '0;
            s_d.por_done  = 1'b0;
            s_d.pin_cnt   = 2'h0;
            s_d.wdog_bite = 1'b0;
            s_d.irq_s1    = 1'b1;
            s_d.irq_s2    = 1'b1;
            s_d.irq_prev  = 1'b1;
            s_d.vec       = rilc_pkg::RILC_VEC_RESET;
            s_d.rdata     = 8'h00;
        end
    end

    always_ff @(posedge clock_in) begin
        s_q <= s_d;
    end

    always_comb begin
        rdata_out          = s_q.rdata;
        core_reset_out     = s_q.st == rilc_pkg::RILC_ST_RESET; // RULE8 RULE9
        periph_reset_out   = s_q.st == rilc_pkg::RILC_ST_RESET; // RULE9 RULE10
        timer_load_out     = rilc_pkg::RILC_TCNT_RESET; // RULE10
        cpu_halt_out       = s_q.mode != rilc_pkg::RILC_MODE_RUN; // RULE5
        osc_run_out        = s_q.mode != rilc_pkg::RILC_MODE_STOP; // RULE1
        irq_mask_out       = s_q.mask;
        timer_en_out       = s_q.ten;
        timer_en_clear_out = (s_q.mode == rilc_pkg::RILC_MODE_STOP) |
                             (s_q.st == rilc_pkg::RILC_ST_RESET); // RULE2 RULE10
        sp_out             = s_q.sp;
        mode_out           = s_q.mode;
        seq_out.valid      = (s_q.st == rilc_pkg::RILC_ST_PUSH) |
                             (s_q.st == rilc_pkg::RILC_ST_PULL);
        seq_out.pull       = s_q.st == rilc_pkg::RILC_ST_PULL;
        seq_out.slot       = s_q.slot;
        seq_out.vec_addr   = (s_q.st == rilc_pkg::RILC_ST_VEC_LO) ? s_q.vec + 16'h0001
                                                                  : s_q.vec;
        seq_out.vec_fetch  = (s_q.st == rilc_pkg::RILC_ST_VEC_HI) |
                             (s_q.st == rilc_pkg::RILC_ST_VEC_LO);
        reset_pin_oe_n_out = 1'b1; // RULE13
    end
endmodule

// ===== rtl/rilc_pkg.sv
// Purpose: constants and carriers for the reset, interrupt and low-power sequencer
// Assumes: 50 MHz clock_in; cpu core drives the request strobes below
// Notes:
// Summary of operation
// RULE1: stop halts oscillator: all processing, timer and watchdog counting freeze.
// RULE2: in stop, clear the three timer interrupt enables, dropping timer requests.
// RULE3: entering stop clears the interrupt mask so external interrupts can wake.
// RULE4: stop ends only on external interrupt or reset; external uses vector 1FFA.
// RULE5: wait halts cpu but keeps timer running; timer interrupt ends wait.
// RULE6: watchdog keeps counting in wait; software must exit and clear it in time.
// RULE7: entering wait clears the interrupt mask, nothing else changes.
// RULE8: any reset aborts the current instruction immediately.
// RULE9: reset clears direction bits, stack pointer to FF, sets mask, clears latches.
// RULE10: reset clears timer divider, loads counter FFFC, clears pin bits and enables.
// RULE11: leaving reset, pc high byte from 1FFE and low byte from 1FFF.
// RULE12: power-on holds reset 4064 cycles, then longer while reset pin stays low.
// RULE13: reset pin is input only, held low 1.5 cycles; never driven by device.
// RULE14: optional 18-stage watchdog, expiry resets like power-on.
// RULE15: writing zero to bit 0 at 1FF0 restarts the watchdog.
// RULE16: interrupts checked after instruction; push pcl, pch, x, a, ccr; set mask.
// RULE17: return pulls ccr, a, x, pch, pcl in that order.
// RULE18: timer interrupt when mask clear and any flag with its enable; vector 1FF8.
// RULE19: external interrupt wins over timer interrupt.
// RULE20: sync irq pin, latch on low, clear latch at vector fetch, relatch during service.
// RULE21: build option selects edge only or edge and level triggering.
// RULE22: software trap ignores mask, vector 1FFC.
// RULE23: edge option latches only on a high-to-low pin transition.
// RULE24: watchdog presence and trigger mode are parameters, not registers.
package rilc_pkg;
    localparam logic [15:0] RILC_WDOG_ADDR    = 16'h1FF0;
    // timer enables are held in rilc_ctl, written through the timer control address
    localparam logic [15:0] RILC_TCR_ADDR     = 16'h0012;
    localparam int          RILC_TEN_MSB      = 7;
    localparam int          RILC_TEN_LSB      = 5;
    localparam int          RILC_WDOG_CLR_BIT = 0;
    localparam logic [15:0] RILC_VEC_TIMER    = 16'h1FF8;
    localparam logic [15:0] RILC_VEC_EXT      = 16'h1FFA;
    localparam logic [15:0] RILC_VEC_TRAP     = 16'h1FFC;
    localparam logic [15:0] RILC_VEC_RESET    = 16'h1FFE;
    localparam logic [7:0]  RILC_SP_RESET     = 8'hFF;
    localparam logic [15:0] RILC_TCNT_RESET   = 16'hFFFC;
    localparam int          RILC_POR_CYCLES   = 4064;
    localparam int          RILC_WDOG_STAGES  = 18;
    localparam logic [1:0]  RILC_RSTPIN_CYC   = 2'h2;
    localparam logic [2:0]  RILC_STACK_LAST   = 3'h4;
    // stack slot codes, push order
    localparam logic [2:0]  RILC_SLOT_PCL = 3'h0;
    localparam logic [2:0]  RILC_SLOT_PCH = 3'h1;
    localparam logic [2:0]  RILC_SLOT_X   = 3'h2;
    localparam logic [2:0]  RILC_SLOT_A   = 3'h3;
    localparam logic [2:0]  RILC_SLOT_CCR = 3'h4;

    typedef enum logic [1:0] {
        RILC_MODE_RUN,
        RILC_MODE_WAIT,
        RILC_MODE_STOP
    } rilc_mode_type;

    typedef enum {
        RILC_ST_RESET,
        RILC_ST_VEC_HI,
        RILC_ST_VEC_LO,
        RILC_ST_RUN,
        RILC_ST_PUSH,
        RILC_ST_PULL
    } rilc_state_type;

    typedef struct packed {
        logic capture_flag;
        logic compare_flag;
        logic overflow_flag;
    } rilc_tflag_type;

    typedef struct packed {
        logic capture_irq_enable;
        logic compare_irq_enable;
        logic overflow_irq_enable;
    } rilc_ten_type;

    typedef struct packed {
        logic        instr_done;
        logic        exec_stop;
        logic        exec_wait;
        logic        exec_trap;
        logic        exec_return;
        logic        mask_set;
        logic        mask_clear;
    } rilc_cpu_req_type;

    typedef struct packed {
        logic        valid;
        logic        pull;
        logic [2:0]  slot;
        logic [15:0] vec_addr;
        logic        vec_fetch;
    } rilc_seq_out_type;
endpackage

// ===== test/rilc_core_model.sv
// Purpose: core and pin sources facing the sequencer
// Assumes: bench asks for one-cycle commands
// Notes: registers every command, so requests land one cycle late
`timescale 1ns/1ps
module rilc_core_model (
    input  wire logic                       clock_in,
    input  wire rilc_pkg::rilc_cpu_req_type cmd_in,
    input  wire logic                       irq_low_in,
    input  wire logic                       rst_low_in,
    output rilc_pkg::rilc_cpu_req_type      cpu_req_out,
    output logic                            irq_pin_n_out,
    output logic                            reset_pin_n_out
);
    logic hold_q;
    always @(posedge clock_in) begin
        cpu_req_out <= cmd_in;
        hold_q <= rst_low_in;
        reset_pin_n_out <= !(rst_low_in || hold_q);
        irq_pin_n_out <= !irq_low_in;
    end
endmodule

// ===== test/rilc_ctl_monitor.sv
// Purpose: port checker for rilc_ctl
// Assumes: one clock domain, rst_in synchronous active high
// Notes: figures follow the hand-over walk
`timescale 1ns/1ps
module rilc_ctl_monitor (
    input wire logic                       clock_in,
    input wire logic                       rst_in,
    input wire logic                       reset_pin_n_in,
    input wire logic                       rd_in,
    input wire logic [7:0]                 rdata_out,
    input wire logic                       core_reset_out,
    input wire logic                       cpu_halt_out,
    input wire logic                       osc_run_out,
    input wire logic                       irq_mask_out,
    input wire rilc_pkg::rilc_ten_type     timer_en_out,
    input wire logic                       periph_reset_out,
    input wire logic [7:0]                 sp_out,
    input wire logic [15:0]                timer_load_out,
    input wire rilc_pkg::rilc_seq_out_type seq_out,
    input wire rilc_pkg::rilc_mode_type    mode_out,
    input wire logic                       reset_pin_oe_n_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    pin_never_driven_a: assert property (reset_pin_oe_n_out)
        else $error("reset pin driven");
    pin_reset_a: assert property (!reset_pin_n_in [*2] |-> ##[0:2] core_reset_out)
        else $error("reset pin ignored");
    reset_state_a: assert property (core_reset_out |-> sp_out == 8'hFF && irq_mask_out
        && timer_en_out == 3'h0 && mode_out == rilc_pkg::RILC_MODE_RUN)
        else $error("reset state wrong");
    timer_load_a: assert property (periph_reset_out |-> timer_load_out == 16'hFFFC
        && core_reset_out) else $error("timer load wrong");
    reset_vector_a: assert property ($fell(core_reset_out) |-> seq_out.vec_fetch
        && seq_out.vec_addr == 16'h1FFE ##1 seq_out.vec_addr == 16'h1FFF)
        else $error("reset vector wrong");
    stop_state_a: assert property (mode_out == rilc_pkg::RILC_MODE_STOP |-> !osc_run_out
        && cpu_halt_out && timer_en_out == 3'h0 && !irq_mask_out) else $error("stop wrong");
    wait_state_a: assert property (mode_out == rilc_pkg::RILC_MODE_WAIT |-> osc_run_out
        && cpu_halt_out && !irq_mask_out) else $error("wait wrong");
    push_order_a: assert property ($rose(seq_out.valid && !seq_out.pull) |->
        seq_out.slot == 3'h0 ##1 seq_out.slot == 3'h1 ##1 seq_out.slot == 3'h2
        ##1 seq_out.slot == 3'h3 ##1 seq_out.slot == 3'h4 ##1 seq_out.vec_fetch && irq_mask_out)
        else $error("push order wrong");
    pull_order_a: assert property ($rose(seq_out.valid && seq_out.pull) |->
        seq_out.slot == 3'h4 ##1 seq_out.slot == 3'h3 ##1 seq_out.slot == 3'h2
        ##1 seq_out.slot == 3'h1 ##1 seq_out.slot == 3'h0) else $error("pull order wrong");
    read_zero_a: assert property (rd_in |=> rdata_out == 8'h00)
        else $error("read not zero");
endmodule
bind rilc_ctl rilc_ctl_monitor i_mon (.clock_in(clock_in), .rst_in(rst_in),
    .reset_pin_n_in(reset_pin_n_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .core_reset_out(core_reset_out), .cpu_halt_out(cpu_halt_out), .osc_run_out(osc_run_out),
    .irq_mask_out(irq_mask_out), .timer_en_out(timer_en_out),
    .periph_reset_out(periph_reset_out), .sp_out(sp_out), .timer_load_out(timer_load_out),
    .seq_out(seq_out), .mode_out(mode_out), .reset_pin_oe_n_out(reset_pin_oe_n_out));

// ===== test/rilc_ctl_tb_top.sv
// Purpose: self-checking bench for rilc_ctl
// Assumes: short counts, por 16 and watchdog 6 stages
// Notes: timer enables are written through the timer control address
`timescale 1ns/1ps
module rilc_ctl_tb_top;
    localparam int POR = 16;
    logic clock_in, rst_in, wr_in, rd_in, irq_low, rst_low, irq_n, rpin_n;
    logic cpu_halt_out, osc_run_out, irq_mask_out, core_reset_out, en_clr, preset, oe_n;
    logic [15:0] addr_in, tload, got_vec;
    logic [7:0] wdata_in, rdata_out, sp_out;
    rilc_pkg::rilc_cpu_req_type cmd, cpu_req;
    rilc_pkg::rilc_tflag_type tflags;
    rilc_pkg::rilc_ten_type ten;
    rilc_pkg::rilc_seq_out_type seq_out;
    rilc_pkg::rilc_mode_type mode_out;
    int num_errors, num_checks, n;
    int got_q[$];
    rilc_core_model i_core (.clock_in(clock_in), .cmd_in(cmd), .irq_low_in(irq_low),
        .rst_low_in(rst_low), .cpu_req_out(cpu_req), .irq_pin_n_out(irq_n),
        .reset_pin_n_out(rpin_n));
    rilc_ctl #(.POR_CYCLES(POR), .WDOG_STAGES(6)) i_dut (.clock_in(clock_in),
        .rst_in(rst_in), .reset_pin_n_in(rpin_n), .irq_pin_n_in(irq_n), .cpu_req_in(cpu_req),
        .timer_flags_in(tflags), .wr_in(wr_in), .rd_in(rd_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .rdata_out(rdata_out), .core_reset_out(core_reset_out),
        .cpu_halt_out(cpu_halt_out), .osc_run_out(osc_run_out), .irq_mask_out(irq_mask_out),
        .timer_en_out(ten), .timer_en_clear_out(en_clr), .periph_reset_out(preset),
        .sp_out(sp_out), .timer_load_out(tload), .seq_out(seq_out), .mode_out(mode_out),
        .reset_pin_oe_n_out(oe_n));
    initial begin
        clock_in = 1'b0;
        forever #10 clock_in = ~clock_in;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clock_in);
    endtask
    task automatic pulse(input logic [6:0] c);
        cmd <= c;
        @(posedge clock_in);
        cmd <= '0;
        @(posedge clock_in);
    endtask
    task automatic write(input logic [15:0] a, input logic [7:0] d);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clock_in);
        wr_in <= 1'b0;
        @(posedge clock_in);
    endtask
    task automatic read(input logic [15:0] a);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clock_in);
        rd_in <= 1'b0;
        @(posedge clock_in);
        check(rdata_out, 8'h00);
    endtask
    task automatic kick();
        tflags <= 3'($urandom_range(1, 7));
        write(16'h1FF0, 8'($urandom) & 8'hFE);
    endtask
    // model: five slots in push order, reversed for a pull
    task automatic expect_seq(input bit pull, input logic [15:0] vec, input int k);
        got_q.delete();
        got_vec = 16'hFFFF;
        repeat (k) begin
            @(posedge clock_in);
            if (seq_out.valid === 1'b1) got_q.push_back(int'(seq_out.slot));
            if (seq_out.vec_fetch === 1'b1 && got_vec === 16'hFFFF) got_vec = seq_out.vec_addr;
        end
        check(got_q.size(), 5);
        foreach (got_q[i]) check(got_q[i], pull ? 4 - i : i);
        if (!pull) check(got_vec, vec);
    endtask
    task automatic wait_level(input logic lvl);
        n = 0;
        while (core_reset_out !== lvl && n < 300) begin
            @(posedge clock_in);
            n++;
        end
    endtask
    initial begin
        {rst_in, wr_in, rd_in, irq_low, rst_low} = 5'h10;
        {addr_in, wdata_in, cmd, tflags} = '0;
        void'($urandom(57459));
        tick(4);
        rst_in <= 1'b0;
        wait_level(1'b0);
        check(n >= POR - 1 && n <= POR + 2, 1);
        tick(3);
        read(16'h0012);
        read(16'h1FF0);
        rst_low <= 1'b1; // external pin reset, held long
        tick(POR + 20);
        check(core_reset_out, 1);
        rst_low <= 1'b0;
        wait_level(1'b0);
        check(n <= 6, 1);
        tick(3);
        kick();
        pulse(7'h01);
        irq_low <= 1'b1;
        tick(2);
        irq_low <= 1'b0;
        tick(3);
        pulse(7'h40);
        expect_seq(0, 16'h1FFA, 12);
        pulse(7'h04);
        expect_seq(1, 16'h0000, 10);
        kick();
        pulse(7'h02);
        pulse(7'h08);
        pulse(7'h40);
        expect_seq(0, 16'h1FFC, 12);
        kick();
        irq_low <= 1'b1;
        tick(3);
        repeat (2) begin
            kick();
            pulse(7'h01);
            pulse(7'h40);
            expect_seq(0, 16'h1FFA, 12);
        end
        kick();
        write(16'h0012, 8'hE0);
        check(ten, 3'h7);
        repeat (2) begin
            pulse(7'h01);
            pulse(7'h40);
            expect_seq(0, irq_low ? 16'h1FFA : 16'h1FF8, 12);
            irq_low <= 1'b0;
            tick(4);
        end
        irq_low <= 1'b0;
        tick(4);
        kick();
        pulse(7'h20);
        tick(3);
        check(mode_out, rilc_pkg::RILC_MODE_STOP);
        check(en_clr, 1);
        tick(150);
        check(core_reset_out, 0);
        irq_low <= 1'b1;
        tick(2);
        irq_low <= 1'b0;
        expect_seq(0, 16'h1FFA, 16);
        check(mode_out, rilc_pkg::RILC_MODE_RUN);
        repeat (8) begin
            kick();
            tick($urandom_range(10, 40));
        end
        check(core_reset_out, 0);
        write(16'h0012, 8'hE0);
        pulse(7'h10);
        expect_seq(0, 16'h1FF8, 12);
        kick();
        write(16'h0012, 8'h00);
        pulse(7'h10);
        tick(3);
        check(mode_out, rilc_pkg::RILC_MODE_WAIT);
        wait_level(1'b1);
        check(core_reset_out, 1);
        wait_level(1'b0);
        check(core_reset_out, 0);
        rst_low <= 1'b1;
        rst_in <= 1'b1;
        tick(2);
        rst_in <= 1'b0;
        tick(POR + 4);
        check(core_reset_out, 1);
        rst_low <= 1'b0;
        wait_level(1'b0);
        check(n <= 6, 1);
        end_of_test();
    end
    initial begin
        #400000;
        num_errors++;
        end_of_test();
    end
endmodule
